// [shared/mem_map_pkg.sv]
`default_nettype none
package mem_map_pkg;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam int VECTOR_STEP_SHIFT = 3;
	localparam logic [15:0] INTERNAL_ROM_TOP = 16'h0FFF;
	localparam int ROM_ADDR_W = 12;
	localparam int STROBE_CYCLES = 4;
	localparam logic [3:0] STROBE_LAST = 4'h3;
	localparam logic [7:0] FLOAT_BYTE = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		KIND_FETCH = 2'h0,
		KIND_READ = 2'h1,
		KIND_WRITE = 2'h2
	} bus_kind_type;

	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_ADDR = 3'h1,
		PH_HOLD = 3'h3,
		PH_STROBE = 3'h2,
		PH_END = 3'h6
	} phase_type;

	typedef enum logic [2:0] {
		ST_READY = 3'h0,
		ST_INT_FETCH = 3'h1,
		ST_EXT_FETCH = 3'h3,
		ST_DATA_WAIT = 3'h2,
		ST_IDLE = 3'h6,
		ST_POWER_DOWN = 3'h7
	} ctrl_state_type;
endpackage : mem_map_pkg
`default_nettype wire

// [shared/bus_cycle_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface bus_cycle_if;
	logic start;
	mem_map_pkg::bus_kind_type kind;
	logic [15:0] addr;
	logic wide;
	logic [7:0] high_byte;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic done;
	modport requester(output start, kind, addr, wide, high_byte, wdata, input rdata, done);
	modport sequencer(input start, kind, addr, wide, high_byte, wdata, output rdata, done);
endinterface : bus_cycle_if
`default_nettype wire

// [logic/ext_bus_cycle.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_bus_cycle (
	input wire logic core_clk_i,
	input wire logic reset_i,
	bus_cycle_if.sequencer cyc,
	input wire logic [7:0] port0_i,
	output logic [7:0] port0_o,
	output logic port0_oe_o,
	output logic [7:0] port2_o,
	output logic addr_latch_strobe_o,
	output logic program_read_strobe_n_o,
	output logic data_read_strobe_n_o,
	output logic data_write_strobe_n_o
);
	localparam int DONE_DELAY = mem_map_pkg::STROBE_CYCLES + 3;
	logic [7:0] port0_meta;
	logic [7:0] port0_sync;
	mem_map_pkg::phase_type phase;
	mem_map_pkg::bus_kind_type kind;
	logic [7:0] wdata;
	logic [3:0] count;
	logic last;

	assign last = (phase == mem_map_pkg::PH_STROBE) && (count == mem_map_pkg::STROBE_LAST);

	// returning code or data byte crosses in from the pins
	always_ff @(posedge core_clk_i) begin
		port0_meta <= port0_i;
		port0_sync <= port0_meta;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			phase <= mem_map_pkg::PH_IDLE;
			count <= 4'h0;
		end else begin
			unique case (phase)
				mem_map_pkg::PH_IDLE: if (cyc.start) phase <= mem_map_pkg::PH_ADDR;
				mem_map_pkg::PH_ADDR: phase <= mem_map_pkg::PH_HOLD;
				mem_map_pkg::PH_HOLD: begin
					phase <= mem_map_pkg::PH_STROBE;
					count <= 4'h0;
				end
				mem_map_pkg::PH_STROBE: begin
					if (last) phase <= mem_map_pkg::PH_END;
					else count <= count + 4'h1;
				end
				mem_map_pkg::PH_END: phase <= mem_map_pkg::PH_IDLE;
				default: phase <= mem_map_pkg::PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			port0_o <= mem_map_pkg::RESET_BYTE;
			port0_oe_o <= 1'b0;
			port2_o <= mem_map_pkg::RESET_BYTE;
			addr_latch_strobe_o <= 1'b0;
			program_read_strobe_n_o <= 1'b1;
			data_read_strobe_n_o <= 1'b1;
			data_write_strobe_n_o <= 1'b1;
			kind <= mem_map_pkg::KIND_FETCH;
			wdata <= mem_map_pkg::RESET_BYTE;
		end else if (phase == mem_map_pkg::PH_IDLE && cyc.start) begin
			// low byte on port 0 while the latch strobe is high, high byte on port 2
			addr_latch_strobe_o <= 1'b1;
			port0_oe_o <= 1'b1;
			port0_o <= cyc.addr[7:0];
			port2_o <= cyc.wide ? cyc.addr[15:8] : cyc.high_byte;
			kind <= cyc.kind;
			wdata <= cyc.wdata;
		end else if (phase == mem_map_pkg::PH_ADDR) begin
			addr_latch_strobe_o <= 1'b0;
		end else if (phase == mem_map_pkg::PH_HOLD) begin
			program_read_strobe_n_o <= kind != mem_map_pkg::KIND_FETCH;
			data_read_strobe_n_o <= kind != mem_map_pkg::KIND_READ;
			data_write_strobe_n_o <= kind != mem_map_pkg::KIND_WRITE;
			if (kind == mem_map_pkg::KIND_WRITE) port0_o <= wdata;
			else port0_oe_o <= 1'b0;
		end else if (last) begin
			program_read_strobe_n_o <= 1'b1;
			data_read_strobe_n_o <= 1'b1;
			data_write_strobe_n_o <= 1'b1;
		end else if (phase == mem_map_pkg::PH_END) begin
			port0_oe_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cyc.done <= 1'b0;
			cyc.rdata <= mem_map_pkg::RESET_BYTE;
		end else begin
			cyc.done <= last;
			if (last) cyc.rdata <= port0_sync;
		end
	end

	property p_latch_addr;
		@(posedge core_clk_i) disable iff (reset_i)
		addr_latch_strobe_o |=> !addr_latch_strobe_o && port0_oe_o && $stable(port0_o);
	endproperty
	a_latch_addr: assert property (p_latch_addr) else $error("address not held past latch strobe");

	property p_fetch_strobe;
		@(posedge core_clk_i) disable iff (reset_i)
		(phase == mem_map_pkg::PH_STROBE && kind == mem_map_pkg::KIND_FETCH) |->
			!program_read_strobe_n_o && data_read_strobe_n_o && !port0_oe_o;
	endproperty
	a_fetch_strobe: assert property (p_fetch_strobe) else $error("fetch strobe wrong");

	property p_write_strobe;
		@(posedge core_clk_i) disable iff (reset_i)
		(phase == mem_map_pkg::PH_STROBE && kind == mem_map_pkg::KIND_WRITE) |->
			!data_write_strobe_n_o && program_read_strobe_n_o && port0_oe_o && port0_o == wdata;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe wrong");

	property p_cycle_length;
		@(posedge core_clk_i) disable iff (reset_i)
		(phase == mem_map_pkg::PH_IDLE && cyc.start) |-> ##DONE_DELAY cyc.done;
	endproperty
	a_cycle_length: assert property (p_cycle_length) else $error("bus cycle length wrong");
endmodule : ext_bus_cycle
`default_nettype wire

// [logic/program_data_memory_interface.sv]
// Overview of operation
// - first fetch after reset from 0000H
// - vectors fixed, 8 bytes apart from 0003H
// - taken interrupt jumps to its vector
// - unused vectors are plain program memory
// - program memory read only, 64K space
// - lowest 4K on chip unless ROM-less
// - strap chooses internal or external low 4K
// - program read strobe for external fetches
// - data read/write strobes for external data
// - data space separate, 8 or 16-bit addresses
// - idle stops core, peripherals keep running
// - power-down stops all, RAM keeps contents
// - no external bus: strobes, long ops absent
// - strap high: below 1000H internal
// - program read strobe quiet on internal fetch
// - port 0 address then write data or float, port 2 high
`timescale 1ns/100ps
`default_nettype none
module program_data_memory_interface #(
	parameter bit HAS_ROM = 1'b1,
	parameter bit HAS_EXT_BUS = 1'b1,
	parameter int ROM_ADDR_W = mem_map_pkg::ROM_ADDR_W
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic external_access_select_i,
	output logic ready_o,
	input wire logic fetch_req_i,
	output logic fetch_valid_o,
	output logic [7:0] fetch_data_o,
	output logic [15:0] fetch_addr_o,
	input wire logic jump_i,
	input wire logic jump_long_i,
	input wire logic [15:0] jump_addr_i,
	input wire logic irq_take_i,
	input wire logic [2:0] irq_index_i,
	output logic rom_rd_o,
	output logic [ROM_ADDR_W-1:0] rom_addr_o,
	input wire logic [7:0] rom_data_i,
	input wire logic xdata_req_i,
	input wire logic xdata_write_i,
	input wire logic xdata_wide_i,
	input wire logic [15:0] xdata_addr_i,
	input wire logic [7:0] xdata_wdata_i,
	input wire logic [7:0] port2_latch_i,
	output logic xdata_done_o,
	output logic [7:0] xdata_rdata_o,
	input wire logic idle_enter_i,
	input wire logic power_down_enter_i,
	input wire logic wake_i,
	output logic core_run_o,
	output logic periph_run_o,
	output logic ram_retain_o,
	input wire logic [7:0] port0_i,
	output logic [7:0] port0_o,
	output logic port0_oe_o,
	output logic [7:0] port2_o,
	output logic addr_latch_strobe_o,
	output logic program_read_strobe_n_o,
	output logic data_read_strobe_n_o,
	output logic data_write_strobe_n_o
);
	bus_cycle_if cyc ();

	mem_map_pkg::ctrl_state_type state;
	mem_map_pkg::ctrl_state_type next_state;
	logic [15:0] pc;
	logic strap_meta;
	logic strap_sync;
	logic strap_pending;
	logic internal_low_sel;
	logic fetched_once;
	logic go;
	logic take_pd;
	logic take_idle;
	logic take_irq;
	logic take_jump;
	logic open_slot;
	logic take_fetch;
	logic take_xdata;
	logic fetch_internal;
	logic fetch_done;
	logic ext_done;

	function automatic logic fetch_is_internal(input logic [15:0] a, input logic sel);
		// vector area gets no decode of its own
		return sel && (a <= mem_map_pkg::INTERNAL_ROM_TOP);
	endfunction : fetch_is_internal

	function automatic logic [15:0] vector_addr(input logic [2:0] idx);
		return mem_map_pkg::VECTOR_BASE + (16'(idx) << mem_map_pkg::VECTOR_STEP_SHIFT);
	endfunction : vector_addr

	// strap pin is asynchronous to the core clock
	always_ff @(posedge core_clk_i) begin
		strap_meta <= external_access_select_i;
		strap_sync <= strap_meta;
	end

	// low-block selection caught in the first cycle after reset release
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			strap_pending <= 1'b1;
			internal_low_sel <= 1'b0;
		end else if (strap_pending) begin
			strap_pending <= 1'b0;
			// ROM-less parts always go external; without a bus the ROM is all there is
			internal_low_sel <= HAS_ROM && (strap_sync || !HAS_EXT_BUS);
		end
	end

	assign fetch_internal = fetch_is_internal(pc, internal_low_sel);
	assign ext_done = HAS_EXT_BUS && cyc.done;

	always_comb begin
		go = (state == mem_map_pkg::ST_READY) && !strap_pending;
		take_pd = go && power_down_enter_i;
		take_idle = go && !power_down_enter_i && idle_enter_i;
		open_slot = go && !power_down_enter_i && !idle_enter_i;
		take_irq = irq_take_i && (open_slot || state == mem_map_pkg::ST_IDLE);
		// long jumps and calls do nothing without an external bus
		take_jump = open_slot && !irq_take_i && jump_i && (HAS_EXT_BUS || !jump_long_i);
		take_fetch = open_slot && !irq_take_i && !jump_i && fetch_req_i;
		take_xdata = open_slot && !irq_take_i && !jump_i && !fetch_req_i && xdata_req_i;
	end

	always_comb begin
		next_state = state;
		unique case (state)
			mem_map_pkg::ST_READY: begin
				if (take_pd) next_state = mem_map_pkg::ST_POWER_DOWN;
				else if (take_idle) next_state = mem_map_pkg::ST_IDLE;
				else if (take_fetch && fetch_internal) next_state = mem_map_pkg::ST_INT_FETCH;
				else if (take_fetch && HAS_EXT_BUS) next_state = mem_map_pkg::ST_EXT_FETCH;
				else if (take_xdata && HAS_EXT_BUS) next_state = mem_map_pkg::ST_DATA_WAIT;
			end
			mem_map_pkg::ST_INT_FETCH: next_state = mem_map_pkg::ST_READY;
			mem_map_pkg::ST_EXT_FETCH: if (ext_done) next_state = mem_map_pkg::ST_READY;
			mem_map_pkg::ST_DATA_WAIT: if (ext_done) next_state = mem_map_pkg::ST_READY;
			mem_map_pkg::ST_IDLE: if (wake_i || take_irq) next_state = mem_map_pkg::ST_READY;
			mem_map_pkg::ST_POWER_DOWN: next_state = mem_map_pkg::ST_POWER_DOWN;
			default: next_state = mem_map_pkg::ST_READY;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) state <= mem_map_pkg::ST_READY;
		else state <= next_state;
	end

	// a fetch with no bus behind it answers at once with the floating-bus value
	assign fetch_done = (state == mem_map_pkg::ST_INT_FETCH) ||
		(state == mem_map_pkg::ST_EXT_FETCH && ext_done) ||
		(take_fetch && !fetch_internal && !HAS_EXT_BUS);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) pc <= mem_map_pkg::RESET_VECTOR;
		else if (take_irq) pc <= vector_addr(irq_index_i);
		else if (take_jump) pc <= jump_addr_i;
		else if (fetch_done) pc <= pc + 16'h0001;
	end

	// program space is only ever read: there is no write path toward it
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rom_rd_o <= 1'b0;
			rom_addr_o <= '0;
		end else begin
			rom_rd_o <= take_fetch && fetch_internal;
			if (take_fetch && fetch_internal) rom_addr_o <= pc[ROM_ADDR_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			fetch_valid_o <= 1'b0;
			fetch_data_o <= mem_map_pkg::RESET_BYTE;
			fetch_addr_o <= mem_map_pkg::RESET_VECTOR;
			fetched_once <= 1'b0;
		end else begin
			fetch_valid_o <= fetch_done;
			if (fetch_valid_o) fetched_once <= 1'b1;
			if (fetch_done) begin
				fetch_addr_o <= pc;
				if (state == mem_map_pkg::ST_INT_FETCH) fetch_data_o <= rom_data_i;
				else if (state == mem_map_pkg::ST_EXT_FETCH) fetch_data_o <= cyc.rdata;
				else fetch_data_o <= mem_map_pkg::FLOAT_BYTE;
			end
		end
	end

	// data space is its own; accesses never touch the program counter
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			xdata_done_o <= 1'b0;
			xdata_rdata_o <= mem_map_pkg::RESET_BYTE;
		end else begin
			xdata_done_o <= (state == mem_map_pkg::ST_DATA_WAIT && ext_done) ||
				(take_xdata && !HAS_EXT_BUS);
			if (state == mem_map_pkg::ST_DATA_WAIT && ext_done) xdata_rdata_o <= cyc.rdata;
			else if (take_xdata && !HAS_EXT_BUS) xdata_rdata_o <= mem_map_pkg::FLOAT_BYTE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cyc.start <= 1'b0;
			cyc.kind <= mem_map_pkg::KIND_FETCH;
			cyc.addr <= mem_map_pkg::RESET_VECTOR;
			cyc.wide <= 1'b1;
			cyc.high_byte <= mem_map_pkg::RESET_BYTE;
			cyc.wdata <= mem_map_pkg::RESET_BYTE;
		end else begin
			cyc.start <= HAS_EXT_BUS && ((take_fetch && !fetch_internal) || take_xdata);
			if (take_fetch) begin
				cyc.kind <= mem_map_pkg::KIND_FETCH;
				cyc.addr <= pc;
				cyc.wide <= 1'b1;
			end else if (take_xdata) begin
				cyc.kind <= xdata_write_i ? mem_map_pkg::KIND_WRITE : mem_map_pkg::KIND_READ;
				cyc.addr <= xdata_addr_i;
				cyc.wide <= xdata_wide_i;
				cyc.high_byte <= port2_latch_i;
				cyc.wdata <= xdata_wdata_i;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ready_o <= 1'b0;
			core_run_o <= 1'b1;
			periph_run_o <= 1'b1;
			ram_retain_o <= 1'b0;
		end else begin
			ready_o <= next_state == mem_map_pkg::ST_READY;
			core_run_o <= next_state != mem_map_pkg::ST_IDLE &&
				next_state != mem_map_pkg::ST_POWER_DOWN;
			periph_run_o <= next_state != mem_map_pkg::ST_POWER_DOWN;
			ram_retain_o <= next_state == mem_map_pkg::ST_POWER_DOWN;
		end
	end

	generate
		if (HAS_EXT_BUS) begin : g_bus
			ext_bus_cycle u_bus (
				.core_clk_i(core_clk_i),
				.reset_i(reset_i),
				.cyc(cyc.sequencer),
				.port0_i(port0_i),
				.port0_o(port0_o),
				.port0_oe_o(port0_oe_o),
				.port2_o(port2_o),
				.addr_latch_strobe_o(addr_latch_strobe_o),
				.program_read_strobe_n_o(program_read_strobe_n_o),
				.data_read_strobe_n_o(data_read_strobe_n_o),
				.data_write_strobe_n_o(data_write_strobe_n_o)
			);
		end else begin : g_no_bus
			// bus pins held idle when the part has no external memory
			assign cyc.done = 1'b0;
			assign cyc.rdata = mem_map_pkg::FLOAT_BYTE;
			assign port0_o = mem_map_pkg::RESET_BYTE;
			assign port0_oe_o = 1'b0;
			assign port2_o = mem_map_pkg::RESET_BYTE;
			assign addr_latch_strobe_o = 1'b0;
			assign program_read_strobe_n_o = 1'b1;
			assign data_read_strobe_n_o = 1'b1;
			assign data_write_strobe_n_o = 1'b1;
		end
	endgenerate

	property p_reset_vector;
		@(posedge core_clk_i) disable iff (reset_i)
		(fetch_valid_o && !fetched_once) |-> fetch_addr_o == mem_map_pkg::RESET_VECTOR;
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("first fetch not at 0000H");

	property p_vector;
		@(posedge core_clk_i) disable iff (reset_i)
		take_irq |=> pc == vector_addr($past(irq_index_i));
	endproperty
	a_vector: assert property (p_vector) else $error("interrupt not at its vector");

	property p_rom_route;
		@(posedge core_clk_i) disable iff (reset_i)
		state == mem_map_pkg::ST_INT_FETCH |-> rom_rd_o && fetch_is_internal(pc, internal_low_sel);
	endproperty
	a_rom_route: assert property (p_rom_route) else $error("internal fetch outside ROM");

	property p_ext_route;
		@(posedge core_clk_i) disable iff (reset_i)
		(cyc.start && cyc.kind == mem_map_pkg::KIND_FETCH) |->
			!fetch_is_internal(cyc.addr, internal_low_sel);
	endproperty
	a_ext_route: assert property (p_ext_route) else $error("external fetch of ROM address");

	property p_internal_quiet;
		@(posedge core_clk_i) disable iff (reset_i)
		state == mem_map_pkg::ST_INT_FETCH |-> program_read_strobe_n_o ##1 program_read_strobe_n_o;
	endproperty
	a_internal_quiet: assert property (p_internal_quiet) else $error("strobe on internal fetch");

	property p_idle;
		@(posedge core_clk_i) disable iff (reset_i)
		(state == mem_map_pkg::ST_IDLE && $past(state) == mem_map_pkg::ST_IDLE) |->
			!core_run_o && periph_run_o;
	endproperty
	a_idle: assert property (p_idle) else $error("idle run flags wrong");

	property p_power_down;
		@(posedge core_clk_i) disable iff (reset_i)
		state == mem_map_pkg::ST_POWER_DOWN |=>
			state == mem_map_pkg::ST_POWER_DOWN && !periph_run_o && !core_run_o && ram_retain_o;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down left");

	property p_strap_hold;
		@(posedge core_clk_i) disable iff (reset_i)
		!strap_pending |=> $stable(internal_low_sel);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap choice changed");

	property p_no_bus;
		@(posedge core_clk_i) disable iff (reset_i)
		!HAS_EXT_BUS |-> program_read_strobe_n_o && !addr_latch_strobe_o && !cyc.start;
	endproperty
	a_no_bus: assert property (p_no_bus) else $error("bus active without bus");
endmodule : program_data_memory_interface
`default_nettype wire

// [bench/ext_memory_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
	input wire logic [7:0] port0_o,
	input wire logic port0_oe_o,
	input wire logic [7:0] port2_o,
	input wire logic addr_latch_strobe_o,
	input wire logic program_read_strobe_n_o,
	input wire logic data_read_strobe_n_o,
	input wire logic data_write_strobe_n_o,
	output logic [7:0] port0_i
);
	logic [7:0] xram [0:65535];
	logic [7:0] low;
	logic [7:0] wbuf;
	logic [7:0] held = 8'h00;
	logic [7:0] val;
	logic [15:0] addr;
	logic read_n;
	assign addr = {port2_o, low};
	// one common read strobe, as a merged program and data memory would see it
	assign read_n = program_read_strobe_n_o & data_read_strobe_n_o;
	assign val = program_read_strobe_n_o ? xram[addr] : addr[7:0] ^ addr[15:8] ^ 8'h5A;
	// released bus shows the inverse of the last byte so stale data cannot pass
	assign port0_i = port0_oe_o ? port0_o : (read_n ? ~held : val);
	always @* begin
		if (addr_latch_strobe_o) low = port0_o;
		if (!read_n) held = val;
		if (!data_write_strobe_n_o) wbuf = port0_o;
	end
	always @(posedge data_write_strobe_n_o) begin
		xram[addr] = wbuf;
	end
endmodule : ext_memory_model
`default_nettype wire

// [bench/program_data_memory_interface_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module program_data_memory_interface_tb;
	logic core_clk_i, reset_i, external_access_select_i, ready_o, fetch_req_i, fetch_valid_o;
	logic [7:0] fetch_data_o, rom_data_i, xdata_wdata_i, port2_latch_i, xdata_rdata_o;
	logic [7:0] port0_i, port0_o, port2_o;
	logic [15:0] fetch_addr_o, jump_addr_i, xdata_addr_i;
	logic [11:0] rom_addr_o;
	logic [2:0] irq_index_i;
	logic jump_i, jump_long_i, irq_take_i, rom_rd_o, xdata_req_i, xdata_write_i, xdata_wide_i;
	logic xdata_done_o, idle_enter_i, power_down_enter_i, wake_i, core_run_o, periph_run_o;
	logic ram_retain_o, port0_oe_o, addr_latch_strobe_o, program_read_strobe_n_o;
	logic data_read_strobe_n_o, data_write_strobe_n_o;
	int errors = 0;
	int checks = 0;
	int strobe_cnt = 0;
	int rom_cnt = 0;
	int clash = 0;
	program_data_memory_interface dut (.core_clk_i, .reset_i, .external_access_select_i,
		.ready_o, .fetch_req_i, .fetch_valid_o, .fetch_data_o, .fetch_addr_o, .jump_i,
		.jump_long_i, .jump_addr_i, .irq_take_i, .irq_index_i, .rom_rd_o, .rom_addr_o,
		.rom_data_i, .xdata_req_i, .xdata_write_i, .xdata_wide_i, .xdata_addr_i,
		.xdata_wdata_i, .port2_latch_i, .xdata_done_o, .xdata_rdata_o, .idle_enter_i,
		.power_down_enter_i, .wake_i, .core_run_o, .periph_run_o, .ram_retain_o, .port0_i,
		.port0_o, .port0_oe_o, .port2_o, .addr_latch_strobe_o, .program_read_strobe_n_o,
		.data_read_strobe_n_o, .data_write_strobe_n_o);
	ext_memory_model memory (.port0_o, .port0_oe_o, .port2_o, .addr_latch_strobe_o,
		.program_read_strobe_n_o, .data_read_strobe_n_o, .data_write_strobe_n_o, .port0_i);
	assign rom_data_i = rom_addr_o[7:0] + 8'h31;
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (!program_read_strobe_n_o) strobe_cnt++;
		if (rom_rd_o) rom_cnt++;
		if (!program_read_strobe_n_o && port0_oe_o) clash++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	// 0 ready, 1 fetch answer, 2 data answer
	task automatic wait_for(input int which);
		int n;
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
			if (n > 60) begin
				errors++;
				conclude();
			end
		end while (!(which == 0 ? ready_o === 1'b1 : which == 1 ? fetch_valid_o === 1'b1 :
			xdata_done_o === 1'b1));
	endtask : wait_for
	// 0 fetch, 1 jump, 2 irq, 3 wide data, 4 narrow data, 5 idle, 6 power-down
	task automatic send(input int what, input logic [15:0] a, input logic [7:0] d,
		input logic w);
		wait_for(0);
		@(posedge core_clk_i);
		jump_addr_i <= a;
		xdata_addr_i <= a;
		xdata_wdata_i <= d;
		xdata_write_i <= w;
		xdata_wide_i <= what == 3;
		irq_index_i <= a[2:0];
		fetch_req_i <= what == 0;
		jump_i <= what == 1;
		irq_take_i <= what == 2;
		xdata_req_i <= what == 3 || what == 4;
		idle_enter_i <= what == 5;
		power_down_enter_i <= what == 6;
		@(posedge core_clk_i);
		fetch_req_i <= 1'b0;
		jump_i <= 1'b0;
		irq_take_i <= 1'b0;
		xdata_req_i <= 1'b0;
		idle_enter_i <= 1'b0;
		power_down_enter_i <= 1'b0;
	endtask : send
	task automatic fetch(input logic [15:0] a, input logic ext);
		logic [7:0] exp_byte;
		strobe_cnt = 0;
		rom_cnt = 0;
		exp_byte = ext ? a[7:0] ^ a[15:8] ^ 8'h5A : a[7:0] + 8'h31;
		send(0, 16'h0000, 8'h00, 1'b0);
		wait_for(1);
		check(fetch_addr_o, a);
		check(fetch_data_o, exp_byte);
		check(strobe_cnt[15:0], 16'(ext ? mem_map_pkg::STROBE_CYCLES : 0));
		check(rom_cnt[15:0], ext ? 16'h0000 : 16'h0001);
	endtask : fetch
	task automatic do_reset(input logic strap);
		@(posedge core_clk_i);
		reset_i <= 1'b1;
		external_access_select_i <= strap;
		repeat (16) @(posedge core_clk_i);
		reset_i <= 1'b0;
	endtask : do_reset
	task automatic t_program_map();
		do_reset(1'b1);
		fetch(16'h0000, 1'b0);
		fetch(16'h0001, 1'b0);
		send(1, 16'h0FFF, 8'h00, 1'b0);
		fetch(16'h0FFF, 1'b0);
		fetch(16'h1000, 1'b1);
		send(1, 16'hFFFF, 8'h00, 1'b0);
		fetch(16'hFFFF, 1'b1);
		check(clash[15:0], 16'h0000);
		$display("done: program map");
	endtask : t_program_map
	task automatic t_vectors();
		for (int i = 0; i < 8; i++) begin
			send(2, 16'(i), 8'h00, 1'b0);
			fetch(16'h0003 + 16'(i * 8), 1'b0);
		end
		$display("done: vectors");
	endtask : t_vectors
	task automatic xfer(input int what, input logic [15:0] a, input logic [7:0] d,
		input logic w);
		send(what, a, d, w);
		wait_for(2);
	endtask : xfer
	task automatic t_data_space();
		strobe_cnt = 0;
		xfer(3, 16'hA55A, 8'h3C, 1'b1);
		xfer(4, 16'h0077, 8'hC3, 1'b1);
		xfer(3, 16'h1277, 8'h00, 1'b0);
		check(xdata_rdata_o, 16'h00C3);
		xfer(3, 16'hA55A, 8'h00, 1'b0);
		check(xdata_rdata_o, 16'h003C);
		check(strobe_cnt[15:0], 16'h0000);
		$display("done: data space");
	endtask : t_data_space
	task automatic t_power();
		send(5, 16'h0000, 8'h00, 1'b0);
		repeat (2) @(negedge core_clk_i);
		check({core_run_o, periph_run_o, ram_retain_o}, 16'h0002);
		@(posedge core_clk_i);
		wake_i <= 1'b1;
		@(posedge core_clk_i);
		wake_i <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		check({core_run_o, periph_run_o, ram_retain_o}, 16'h0006);
		send(6, 16'h0000, 8'h00, 1'b0);
		repeat (2) @(negedge core_clk_i);
		check({core_run_o, periph_run_o, ram_retain_o}, 16'h0001);
		$display("done: power modes");
	endtask : t_power
	task automatic t_strap_low();
		do_reset(1'b0);
		fetch(16'h0000, 1'b1);
		@(posedge core_clk_i);
		external_access_select_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		send(1, 16'h0002, 8'h00, 1'b0);
		fetch(16'h0002, 1'b1);
		$display("done: strap low");
	endtask : t_strap_low
	initial begin
		reset_i = 1'b1;
		external_access_select_i = 1'b1;
		fetch_req_i = 1'b0;
		jump_i = 1'b0;
		jump_long_i = 1'b1;
		jump_addr_i = 16'h0000;
		irq_take_i = 1'b0;
		irq_index_i = 3'h0;
		xdata_req_i = 1'b0;
		xdata_write_i = 1'b0;
		xdata_wide_i = 1'b0;
		xdata_addr_i = 16'h0000;
		xdata_wdata_i = 8'h00;
		port2_latch_i = 8'h12;
		idle_enter_i = 1'b0;
		power_down_enter_i = 1'b0;
		wake_i = 1'b0;
		t_program_map();
		t_vectors();
		t_data_space();
		t_power();
		t_strap_low();
		conclude();
	end
endmodule : program_data_memory_interface_tb
`default_nettype wire
